// file: pmic_regs_pkg.sv
// constants, types and register layout for the rail enable and resume flag registers
// Function
// - flag set if rail kept on through suspend
// - flag clear from off or rail off
// - unlock key register always reads zero
// - host writes key to unlock protected registers
// - buck6 clear ignored once seal broken
// - seal status zero intact, one broken
// - sequencer overrides bucks1-4, switch1, linreg enables
// - enable bit one turns rail on
// - pin3 low on zero, high-impedance on one
// - warm-reset option disables pin3 output bit
// - warm-reset option makes pin3 bucks1-2 reset input
// - output2 open-drain, ignored while pairing set
// - output1 open-drain, ignored while pairing set
// - pairing makes pin1 input driving output2
package pmic_regs_pkg;

  localparam logic [7:0] ADDR_RESUME_FLAGS = 8'h07;
  localparam logic [7:0] ADDR_UNLOCK_KEY = 8'h10;
  localparam logic [7:0] ADDR_CONV_EN = 8'h11;
  localparam logic [7:0] ADDR_SW_EN = 8'h12;

  localparam logic [7:0] RESET_RESUME_FLAGS = 8'h00;
  localparam logic [7:0] RESET_CONV_EN = 8'h00;
  localparam logic [7:0] RESET_SW_EN = 8'h00;
  localparam logic [7:0] KEY_READ_VALUE = 8'h00;

  // writable bits; everything else reads zero
  localparam logic [7:0] CONV_EN_WRITE_MASK = 8'h3f;
  localparam logic [7:0] SW_EN_WRITE_MASK = 8'h7f;

  localparam int BUCK6_ON_BIT = 5;
  localparam int SWITCH1_ON_BIT = 1;
  localparam int LINREG_ON_BIT = 0;
  localparam int PIN1_LEVEL_BIT = 4;
  localparam int PIN2_LEVEL_BIT = 5;
  localparam int PIN3_LEVEL_BIT = 6;

  localparam logic [7:0] UNLOCK_KEY_VALUE = 8'h5a;
  localparam logic [6:0] DEVICE_BUS_ADDR = 7'h2b;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK,
    ST_WRITE,
    ST_READ,
    ST_RACK
  } serial_state_type;

endpackage : pmic_regs_pkg

// file: pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_n_i, // synchronised reset, active low
  input wire logic [WIDTH-1:0] pin_i, // raw pin levels
  output logic [WIDTH-1:0] level_o // filtered levels
);
  initial begin
    if (WIDTH < 1) $error("pin_sync width must be at least one");
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic s1_q, s2_q, s3_q, lvl_q, lvl_d;
      always_comb begin
        lvl_d = lvl_q;
        // s1 is only read by s2; a change counts once s2 and s3 agree
        if (s2_q == s3_q) lvl_d = s3_q;
      end
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          lvl_q <= 1'b1;
        end else begin
          s1_q <= pin_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          lvl_q <= lvl_d;
        end
      end
      assign level_o[g] = lvl_q;
    end
  endgenerate
endmodule : pin_sync

// file: serial_reg_slave.sv
// two-wire serial slave: subaddress pointer, byte writes and auto-increment reads
`timescale 1ns/1ps
module serial_reg_slave #(
  parameter logic [6:0] BUS_ADDR = pmic_regs_pkg::DEVICE_BUS_ADDR
) (
  input wire logic ref_clk_i, // system clock
  input wire logic rst_n_i, // synchronised reset, active low
  input wire logic scl_i, // filtered clock line
  input wire logic sda_i, // filtered data line
  input wire logic [7:0] rdata_i, // read data at ptr_o
  output logic sda_oe_n_o, // low while pulling data line low
  output logic [7:0] ptr_o, // register pointer
  output logic wr_stb_o, // one-cycle write strobe
  output logic [7:0] wr_addr_o, // write address
  output logic [7:0] wr_data_o // write data
);
  pmic_regs_pkg::serial_state_type st_q, st_d;
  logic scl_q, sda_q, rw_q, rw_d, got_ptr_q, got_ptr_d, nack_q, nack_d;
  logic drive_q, drive_d, wr_stb_d, oe_n_q;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, wa_q, wa_d, wd_q, wd_d;
  logic rise, fall, start, stop;

  assign rise = scl_i & ~scl_q;
  assign fall = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop = scl_i & scl_q & ~sda_q & sda_i;

  always_comb begin
    st_d = st_q;
    rw_d = rw_q;
    got_ptr_d = got_ptr_q;
    nack_d = nack_q;
    drive_d = drive_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    wa_d = wa_q;
    wd_d = wd_q;
    wr_stb_d = 1'b0;
    if (start) begin
      st_d = pmic_regs_pkg::ST_ADDR;
      cnt_d = 4'h0;
      drive_d = 1'b0;
      got_ptr_d = 1'b0;
    end else if (stop) begin
      st_d = pmic_regs_pkg::ST_IDLE;
      drive_d = 1'b0;
    end else begin
      case (st_q)
        pmic_regs_pkg::ST_ADDR, pmic_regs_pkg::ST_WRITE: begin
          if (rise && cnt_q != 4'h8) begin
            sh_d = {sh_q[6:0], sda_i};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            if (st_q == pmic_regs_pkg::ST_ADDR) begin
              if (sh_q[7:1] == BUS_ADDR) begin
                rw_d = sh_q[0];
                drive_d = 1'b1;
                st_d = pmic_regs_pkg::ST_ACK;
              end else begin
                st_d = pmic_regs_pkg::ST_IDLE;
              end
            end else begin
              drive_d = 1'b1;
              st_d = pmic_regs_pkg::ST_ACK;
              if (!got_ptr_q) begin
                ptr_d = sh_q;
                got_ptr_d = 1'b1;
              end else begin
                wr_stb_d = 1'b1;
                wa_d = ptr_q;
                wd_d = sh_q;
                ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        pmic_regs_pkg::ST_ACK: begin
          if (fall) begin
            if (rw_q) begin
              tx_d = rdata_i;
              drive_d = ~rdata_i[7];
              st_d = pmic_regs_pkg::ST_READ;
            end else begin
              drive_d = 1'b0;
              st_d = pmic_regs_pkg::ST_WRITE;
            end
          end
        end
        pmic_regs_pkg::ST_READ: begin
          if (fall) begin
            tx_d = {tx_q[6:0], 1'b0};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
              cnt_d = 4'h0;
              drive_d = 1'b0;
              ptr_d = ptr_q + 8'h01;
              st_d = pmic_regs_pkg::ST_RACK;
            end else begin
              drive_d = ~tx_q[6];
            end
          end
        end
        pmic_regs_pkg::ST_RACK: begin
          if (rise) nack_d = sda_i;
          if (fall) begin
            if (nack_q) begin
              st_d = pmic_regs_pkg::ST_IDLE;
            end else begin
              tx_d = rdata_i;
              drive_d = ~rdata_i[7];
              st_d = pmic_regs_pkg::ST_READ;
            end
          end
        end
        default: begin
          drive_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= pmic_regs_pkg::ST_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rw_q <= 1'b0;
      got_ptr_q <= 1'b0;
      nack_q <= 1'b0;
      drive_q <= 1'b0;
      oe_n_q <= 1'b1;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      wa_q <= 8'h00;
      wd_q <= 8'h00;
      wr_stb_o <= 1'b0;
    end else begin
      st_q <= st_d;
      scl_q <= scl_i;
      sda_q <= sda_i;
      rw_q <= rw_d;
      got_ptr_q <= got_ptr_d;
      nack_q <= nack_d;
      drive_q <= drive_d;
      // kept as its own flop so the pin enable leaves no gate after the register
      oe_n_q <= ~drive_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      wr_stb_o <= wr_stb_d;
    end
  end

  assign sda_oe_n_o = oe_n_q;
  assign ptr_o = ptr_q;
  assign wr_addr_o = wa_q;
  assign wr_data_o = wd_q;
endmodule : serial_reg_slave

// file: pmic_rail_enable_and_flag_regs.sv
// rail enable, unlock key and resume flag registers with open-drain pin control
`timescale 1ns/1ps
module pmic_rail_enable_and_flag_regs #(
  parameter logic [6:0] BUS_ADDR = pmic_regs_pkg::DEVICE_BUS_ADDR
) (
  input wire logic ref_clk_i, // 10 MHz clock
  input wire logic arst_n_i, // asynchronous reset, active low
  input wire logic scl_i, // serial clock pin
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // serial data drive level
  output logic sda_oe_n_o, // low while pulling data low
  input wire logic freshness_seal_status_i, // 0 intact, 1 broken
  input wire logic pin_pairing_select_i, // pin1 becomes input for output2
  input wire logic warm_reset_pin_option_i, // pin3 becomes warm reset input
  input wire logic seq_update_i, // sequencer rewrite pulse
  input wire logic [3:0] seq_buck_on_i, // sequencer buck4..1 enables
  input wire logic seq_switch1_on_i, // sequencer switch1 enable
  input wire logic seq_linreg_on_i, // sequencer linreg enable
  input wire logic power_up_i, // power-up completed pulse
  input wire logic from_suspend_i, // power-up came from suspend
  input wire logic [7:0] suspend_enables_i, // rails enabled during suspend
  output logic [5:0] buck_on_o, // buck6..1 enables
  output logic [2:0] switch_on_o, // switch3..1 enables
  output logic linreg_on_o, // linreg enable
  input wire logic pin1_i, // pin1 level
  output logic pin1_o, // pin1 drive level
  output logic pin1_oe_n_o, // low while pulling pin1 low
  output logic pin2_o, // output2 drive level
  output logic pin2_oe_n_o, // low while pulling output2 low
  input wire logic pin3_i, // pin3 level
  output logic pin3_o, // pin3 drive level
  output logic pin3_oe_n_o, // low while pulling pin3 low
  output logic warm_reset_bucks12_o // one-cycle warm reset pulse
);
  logic rst_a_q, rst_n;
  logic scl_f, sda_f, pin1_f, pin3_f;
  logic wr_stb;
  logic [7:0] wr_addr, wr_data, ptr, rdata;
  logic [7:0] conv_q, conv_d, sw_q, sw_d, flags_q, flags_d;
  logic armed_q, armed_d;
  logic p1_q, p1_d, p2_q, p2_d, p3_q, p3_d, p3_prev_q, wr_q, wr_d;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_a_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n <= rst_a_q;
    end
  end

  pin_sync #(.WIDTH(4)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .pin_i({scl_i, sda_i, pin1_i, pin3_i}),
    .level_o({scl_f, sda_f, pin1_f, pin3_f})
  );

  serial_reg_slave #(.BUS_ADDR(BUS_ADDR)) u_bus (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .scl_i(scl_f),
    .sda_i(sda_f),
    .rdata_i(rdata),
    .sda_oe_n_o(sda_oe_n_o),
    .ptr_o(ptr),
    .wr_stb_o(wr_stb),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  // open drain: only ever drive low
  assign sda_o = 1'b0;
  assign pin1_o = 1'b0;
  assign pin2_o = 1'b0;
  assign pin3_o = 1'b0;

  function automatic logic [7:0] read_reg(input logic [7:0] a, input logic [7:0] fl, input logic [7:0] cv,
                                          input logic [7:0] sw);
    case (a)
      pmic_regs_pkg::ADDR_RESUME_FLAGS: read_reg = fl;
      pmic_regs_pkg::ADDR_UNLOCK_KEY: read_reg = pmic_regs_pkg::KEY_READ_VALUE;
      pmic_regs_pkg::ADDR_CONV_EN: read_reg = cv & pmic_regs_pkg::CONV_EN_WRITE_MASK;
      pmic_regs_pkg::ADDR_SW_EN: read_reg = sw & pmic_regs_pkg::SW_EN_WRITE_MASK;
      default: read_reg = 8'h00;
    endcase
  endfunction : read_reg

  assign rdata = read_reg(ptr, flags_q, conv_q, sw_q);

  // enable registers, unlock state
  always_comb begin
    conv_d = conv_q;
    sw_d = sw_q;
    armed_d = armed_q;
    if (wr_stb) begin
      // one unlock buys exactly one protected write; any other write re-locks
      if (wr_addr == pmic_regs_pkg::ADDR_UNLOCK_KEY) begin
        armed_d = (wr_data == pmic_regs_pkg::UNLOCK_KEY_VALUE);
      end else begin
        armed_d = 1'b0;
      end
      if (armed_q && wr_addr == pmic_regs_pkg::ADDR_CONV_EN) begin
        conv_d = wr_data & pmic_regs_pkg::CONV_EN_WRITE_MASK;
        // broken seal (status one) keeps buck6 on
        if (freshness_seal_status_i && conv_q[pmic_regs_pkg::BUCK6_ON_BIT]) begin
          conv_d[pmic_regs_pkg::BUCK6_ON_BIT] = 1'b1;
        end
      end
      if (armed_q && wr_addr == pmic_regs_pkg::ADDR_SW_EN) begin
        sw_d = wr_data & pmic_regs_pkg::SW_EN_WRITE_MASK;
      end
    end
    // sequencer wins over a software write in the same cycle
    if (seq_update_i) begin
      conv_d[3:0] = seq_buck_on_i;
      sw_d[pmic_regs_pkg::SWITCH1_ON_BIT] = seq_switch1_on_i;
      sw_d[pmic_regs_pkg::LINREG_ON_BIT] = seq_linreg_on_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      conv_q <= pmic_regs_pkg::RESET_CONV_EN;
      sw_q <= pmic_regs_pkg::RESET_SW_EN;
      armed_q <= 1'b0;
    end else begin
      conv_q <= conv_d;
      sw_q <= sw_d;
      armed_q <= armed_d;
    end
  end

  // resume flags: loaded only by power-up, never by the bus
  always_comb begin
    flags_d = flags_q;
    if (power_up_i) begin
      flags_d = from_suspend_i ? suspend_enables_i : 8'h00;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= pmic_regs_pkg::RESET_RESUME_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  // pin control; oe_n high means high-impedance
  always_comb begin
    p1_d = pin_pairing_select_i ? 1'b1 : sw_q[pmic_regs_pkg::PIN1_LEVEL_BIT];
    p2_d = pin_pairing_select_i ? pin1_f : sw_q[pmic_regs_pkg::PIN2_LEVEL_BIT];
    p3_d = warm_reset_pin_option_i ? 1'b1 : sw_q[pmic_regs_pkg::PIN3_LEVEL_BIT];
    // falling edge of pin3 only, so a held-low pin resets once
    wr_d = warm_reset_pin_option_i & p3_prev_q & ~pin3_f;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      p1_q <= 1'b0;
      p2_q <= 1'b0;
      p3_q <= 1'b0;
      p3_prev_q <= 1'b1;
      wr_q <= 1'b0;
    end else begin
      p1_q <= p1_d;
      p2_q <= p2_d;
      p3_q <= p3_d;
      p3_prev_q <= pin3_f;
      wr_q <= wr_d;
    end
  end

  assign pin1_oe_n_o = p1_q;
  assign pin2_oe_n_o = p2_q;
  assign pin3_oe_n_o = p3_q;
  assign warm_reset_bucks12_o = wr_q;
  assign buck_on_o = conv_q[5:0];
  assign switch_on_o = sw_q[3:1];
  assign linreg_on_o = sw_q[0];

  key_reads_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (ptr == pmic_regs_pkg::ADDR_UNLOCK_KEY) |-> (rdata == 8'h00))
    else $error("unlock key read back nonzero");

  flags_from_suspend_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (power_up_i && from_suspend_i) |=> (flags_q == $past(suspend_enables_i)))
    else $error("resume flags not loaded from suspend enables");

  flags_from_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (power_up_i && !from_suspend_i) |=> (flags_q == 8'h00))
    else $error("resume flags not cleared on power-up from off");

  locked_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (wr_stb && !armed_q && wr_addr == pmic_regs_pkg::ADDR_SW_EN && !seq_update_i) |=> $stable(sw_q))
    else $error("enable register changed without unlock");

  unlock_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (wr_stb && armed_q && wr_addr == pmic_regs_pkg::ADDR_SW_EN && !seq_update_i)
    |=> (switch_on_o == $past(wr_data[3:1])) && (linreg_on_o == $past(wr_data[0])))
    else $error("unlocked write did not reach rail enables");

  buck6_kept_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (wr_stb && armed_q && wr_addr == pmic_regs_pkg::ADDR_CONV_EN && freshness_seal_status_i && conv_q[5])
    |=> buck_on_o[5])
    else $error("buck6 cleared with seal broken");

  seq_override_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    seq_update_i |=> (buck_on_o[3:0] == $past(seq_buck_on_i)) && (switch_on_o[0] == $past(seq_switch1_on_i)))
    else $error("sequencer rewrite lost");

  reserved_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (conv_q[7:6] == 2'b00) && !sw_q[7])
    else $error("reserved enable bits set");

  pin3_option_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    warm_reset_pin_option_i |=> pin3_oe_n_o)
    else $error("pin3 driven under warm reset option");

  pin3_drive_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !warm_reset_pin_option_i |=> (pin3_oe_n_o == $past(sw_q[6])))
    else $error("pin3 does not follow its output bit");

  pin1_pairing_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    pin_pairing_select_i |=> pin1_oe_n_o && (pin2_oe_n_o == $past(pin1_f)))
    else $error("pairing mode pin mismatch");

  pin1_plain_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    !pin_pairing_select_i |=> (pin1_oe_n_o == $past(sw_q[4])) && (pin2_oe_n_o == $past(sw_q[5])))
    else $error("output1 or output2 does not follow its bit");

  warm_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    (warm_reset_pin_option_i && p3_prev_q && !pin3_f) |=> warm_reset_bucks12_o ##1 !warm_reset_bucks12_o)
    else $error("warm reset pulse wrong");
endmodule : pmic_rail_enable_and_flag_regs

// file: host_serial_model.sv
// host processor model: master on the two-wire register bus
`timescale 1ns/1ps
module host_serial_model (
  input wire logic ref_clk_i, // system clock, paces the bus
  input wire logic sda_i, // resolved data line
  output logic scl_o, // serial clock, high outside frames
  output logic sda_pull_o // one pulls the data line low
);
  localparam int HALF_CYCLES = 10;

  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic half_bit();
    repeat (HALF_CYCLES) @(negedge ref_clk_i);
  endtask : half_bit

  // also serves as repeated start
  task automatic start_cond();
    sda_pull_o = 1'b0;
    half_bit();
    scl_o = 1'b1;
    half_bit();
    sda_pull_o = 1'b1;
    half_bit();
    scl_o = 1'b0;
    half_bit();
  endtask : start_cond

  task automatic stop_cond();
    sda_pull_o = 1'b1;
    half_bit();
    scl_o = 1'b1;
    half_bit();
    sda_pull_o = 1'b0;
    half_bit();
  endtask : stop_cond

  // data moves two cycles after scl falls so the filter never sees both edges at once
  task automatic clock_bit(input logic pull, output logic level);
    sda_pull_o = pull;
    half_bit();
    scl_o = 1'b1;
    half_bit();
    level = sda_i;
    scl_o = 1'b0;
    repeat (2) @(negedge ref_clk_i);
  endtask : clock_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic lvl;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(~b[i], lvl);
    end
    clock_bit(1'b0, lvl);
    ack = ~lvl;
  endtask : send_byte

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic lvl;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b0, lvl);
      b[i] = lvl;
    end
    clock_bit(~last, lvl);
  endtask : recv_byte
endmodule : host_serial_model

// file: pmic_rail_enable_and_flag_regs_tb_top.sv
// self-checking bench for the rail enable, unlock key and resume flag registers
`timescale 1ns/1ps
module pmic_rail_enable_and_flag_regs_tb_top;
  localparam logic [7:0] A_FLAG = pmic_regs_pkg::ADDR_RESUME_FLAGS;
  localparam logic [7:0] A_KEY = pmic_regs_pkg::ADDR_UNLOCK_KEY;
  localparam logic [7:0] A_CONV = pmic_regs_pkg::ADDR_CONV_EN;
  localparam logic [7:0] A_SW = pmic_regs_pkg::ADDR_SW_EN;
  localparam logic [6:0] DEV = pmic_regs_pkg::DEVICE_BUS_ADDR;
  logic ref_clk, arst_n, scl, host_pull, sda, sda_oe_n;
  logic seal, pairing, warm_opt, seq_update, seq_sw1, seq_lin, power_up, from_susp;
  logic [3:0] seq_buck;
  logic [7:0] susp_en, d, e, rdat;
  logic [5:0] buck_on;
  logic [2:0] switch_on;
  logic linreg_on, pin1_drv, pin3_drv, pin1_oe_n, pin2_oe_n, pin3_oe_n, warm_pulse, pin1, pin3;
  logic [7:0] addrs [5] = '{8'h07, 8'h10, 8'h11, 8'h12, 8'h20};
  int n_errors = 0;
  int checks = 0;
  int pulses;

  // lines with pull-ups: low while anyone pulls
  assign sda = ~host_pull & sda_oe_n;
  assign pin1 = pin1_oe_n ? pin1_drv : 1'b0;
  assign pin3 = pin3_oe_n ? pin3_drv : 1'b0;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  pmic_rail_enable_and_flag_regs i_pmic_rail_enable_and_flag_regs (
    .ref_clk_i(ref_clk), .arst_n_i(arst_n), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n),
    .freshness_seal_status_i(seal), .pin_pairing_select_i(pairing), .warm_reset_pin_option_i(warm_opt),
    .seq_update_i(seq_update), .seq_buck_on_i(seq_buck), .seq_switch1_on_i(seq_sw1),
    .seq_linreg_on_i(seq_lin), .power_up_i(power_up), .from_suspend_i(from_susp),
    .suspend_enables_i(susp_en), .buck_on_o(buck_on), .switch_on_o(switch_on), .linreg_on_o(linreg_on),
    .pin1_i(pin1), .pin1_o(), .pin1_oe_n_o(pin1_oe_n), .pin2_o(), .pin2_oe_n_o(pin2_oe_n),
    .pin3_i(pin3), .pin3_o(), .pin3_oe_n_o(pin3_oe_n), .warm_reset_bucks12_o(warm_pulse)
  );

  host_serial_model i_host_serial_model (
    .ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(host_pull)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask : chk

  task automatic test_done();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic a0, a1, a2;
    i_host_serial_model.start_cond();
    i_host_serial_model.send_byte({DEV, 1'b0}, a0);
    i_host_serial_model.send_byte(addr, a1);
    i_host_serial_model.send_byte(data, a2);
    i_host_serial_model.stop_cond();
    chk({5'h00, a0, a1, a2}, 8'h07);
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    logic a0, a1, a2;
    i_host_serial_model.start_cond();
    i_host_serial_model.send_byte({DEV, 1'b0}, a0);
    i_host_serial_model.send_byte(addr, a1);
    i_host_serial_model.start_cond();
    i_host_serial_model.send_byte({DEV, 1'b1}, a2);
    i_host_serial_model.recv_byte(1'b1, data);
    i_host_serial_model.stop_cond();
    chk({5'h00, a0, a1, a2}, 8'h07);
  endtask : rd

  task automatic unlock_wr(input logic [7:0] addr, input logic [7:0] data);
    wr(A_KEY, pmic_regs_pkg::UNLOCK_KEY_VALUE);
    wr(addr, data);
  endtask : unlock_wr

  // a set buck6 survives a clear once the seal is broken
  function automatic logic [7:0] conv_exp(input logic [7:0] old, input logic [7:0] nw, input logic sl);
    conv_exp = nw & pmic_regs_pkg::CONV_EN_WRITE_MASK;
    if (sl && old[5]) begin
      conv_exp[5] = 1'b1;
    end
  endfunction : conv_exp

  task automatic pulse(ref logic sig);
    @(negedge ref_clk);
    sig = 1'b1;
    @(negedge ref_clk);
    sig = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask : pulse

  initial begin
    repeat (100000) @(posedge ref_clk);
    chk(8'h00, 8'hff);
    test_done();
  end

  initial begin
    void'($urandom(32));
    {arst_n, seal, pairing, warm_opt, seq_update, seq_sw1, seq_lin, power_up, from_susp} = '0;
    {seq_buck, susp_en} = '0;
    pin1_drv = 1'b1;
    pin3_drv = 1'b1;
    repeat (16) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk({buck_on, linreg_on, 1'b0}, 8'h00);
    chk({switch_on, pin1_oe_n, pin2_oe_n, pin3_oe_n, 2'b00}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      rd(addrs[i], rdat);
      chk(rdat, 8'h00);
    end
    $display("reset values done");
    wr(A_CONV, 8'h3f);
    unlock_wr(8'h30, 8'h00);
    wr(A_CONV, 8'h3f);
    rd(A_CONV, rdat);
    chk(rdat, 8'h00);
    chk({2'b00, buck_on}, 8'h00);
    $display("write lock done");
    d = 8'h00;
    for (int i = 0; i < 4; i++) begin
      e = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      unlock_wr(A_CONV, e);
      d = conv_exp(d, e, 1'b0);
      rd(A_CONV, rdat);
      chk(rdat, d);
      chk({2'b00, buck_on}, d);
      unlock_wr(A_SW, e);
      rd(A_SW, rdat);
      chk(rdat, e & pmic_regs_pkg::SW_EN_WRITE_MASK);
      chk({4'h0, switch_on, linreg_on}, {4'h0, e[3:0]});
      chk({5'h00, pin3_oe_n, pin2_oe_n, pin1_oe_n}, {5'h00, e[6:4]});
    end
    $display("enable registers done");
    seal = 1'b1;
    unlock_wr(A_CONV, 8'h3f);
    unlock_wr(A_CONV, 8'h00);
    rd(A_CONV, rdat);
    chk(rdat, conv_exp(8'h3f, 8'h00, 1'b1));
    seal = 1'b0;
    unlock_wr(A_CONV, 8'h00);
    chk({2'b00, buck_on}, conv_exp(8'h20, 8'h00, 1'b0));
    $display("seal done");
    unlock_wr(A_CONV, 8'h30);
    unlock_wr(A_SW, 8'h0c);
    for (int i = 0; i < 4; i++) begin
      {seq_buck, seq_sw1, seq_lin} = 6'($urandom);
      pulse(seq_update);
      chk({2'b00, buck_on}, {4'h3, seq_buck});
      chk({4'h0, switch_on, linreg_on}, {4'h0, 2'b11, seq_sw1, seq_lin});
    end
    $display("sequencer done");
    unlock_wr(A_SW, 8'h70);
    pairing = 1'b1;
    pin1_drv = 1'b0;
    repeat (12) @(negedge ref_clk);
    chk({6'h00, pin1_oe_n, pin2_oe_n}, 8'h02);
    pin1_drv = 1'b1;
    unlock_wr(A_SW, 8'h00);
    chk({6'h00, pin1_oe_n, pin2_oe_n}, 8'h03);
    warm_opt = 1'b1;
    repeat (12) @(negedge ref_clk);
    chk({7'h00, pin3_oe_n}, 8'h01);
    pulses = 0;
    pin3_drv = 1'b0;
    for (int i = 0; i < 20; i++) begin
      @(negedge ref_clk);
      pulses += int'(warm_pulse === 1'b1);
    end
    chk(8'(pulses), 8'h01);
    {pairing, warm_opt, pin3_drv} = 3'b001;
    $display("pins done");
    for (int i = 0; i < 3; i++) begin
      susp_en = (i == 0) ? 8'hff : 8'($urandom);
      from_susp = 1'b1;
      pulse(power_up);
      wr(A_FLAG, ~susp_en);
      rd(A_FLAG, rdat);
      chk(rdat, susp_en);
      from_susp = 1'b0;
      pulse(power_up);
      rd(A_FLAG, rdat);
      chk(rdat, 8'h00);
    end
    wr(A_KEY, 8'hff);
    rd(A_KEY, rdat);
    chk(rdat, pmic_regs_pkg::KEY_READ_VALUE);
    $display("flags and key done");
    test_done();
  end
endmodule : pmic_rail_enable_and_flag_regs_tb_top
